// ==== rtl/tcsf_top.sv ====
/*
 * Status flag logic for timer channels 1 and 2 with an Avalon-MM slave.
 * Assumes timer inputs driven on sys_clk and an Avalon waitrequest master.
 */
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
// Functional notes
// - Ch1 reg B flag sets on capture into or match with reg B.
// - Ch1 reg A flag sets on capture into or match with reg A.
// - A flag clears only when read as one and then written with zero.
// - Writing one to a flag leaves it unchanged.
// - Counter 1B wrapping from all ones to zero sets bit 8 of its status.
// - Counter 1B equal to the output compare value sets bit 0 of its status.
// - Unused bits of all three status registers read as zero.
// - All three status registers reset to all zeros.
// - Counter 2A wrapping from all ones to zero sets bit 8 of its status.
// - Bits 7 to 0 of the ch2 status follow general registers H to A.
// - In compare role, counter 2A equal to reg H sets bit 7.
// - Ch2 reg E sets bit 4 on capture or on compare match.
`timescale 1ns/10ps
module tcsf_top
    import tcsf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [ADDR_WIDTH-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_WIDTH-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_WIDTH-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [CNT_WIDTH-1:0] ch1FreeCounterA,
    input wire logic [CNT_WIDTH-1:0] ch1CaptureCompareRegA,
    input wire logic [CNT_WIDTH-1:0] ch1CaptureCompareRegB,
    input wire logic [CH1_GEN_FLAG_COUNT-1:0] ch1CaptureStrobe,
    input wire logic [CNT_WIDTH-1:0] ch1FreeCounterB,
    input wire logic [CNT_WIDTH-1:0] ch1OutputCompareValue,
    input wire logic [CNT_WIDTH-1:0] ch2FreeCounterA,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegA,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegB,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegC,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegD,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegE,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegF,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegG,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegH,
    input wire logic [CH2_GEN_FLAG_COUNT-1:0] ch2CaptureStrobe,
    output logic [CH1_GEN_FLAG_COUNT-1:0] ch1GeneralRegEventFlag,
    output logic ch1CounterBWrapFlag,
    output logic ch1OutputCompareMatchFlag,
    output logic ch2CounterAWrapFlag,
    output logic [CH2_GEN_FLAG_COUNT-1:0] ch2GeneralRegEventFlag
);

    // ****************************************************************
    // Bus handshake
    // ****************************************************************

    logic waitrequest_reg;
    logic [DATA_WIDTH-1:0] readdata_reg;
    logic [DATA_WIDTH-1:0] readdata_next;
    logic readAccept;
    logic writeAccept;
    logic [1:0] laneWrite;

    // Reads are taken while waitrequest is high, so each qualifier sees the
    // returned value; writes land where the master sees waitrequest low.
    assign readAccept = avs_read && waitrequest_reg;
    assign writeAccept = avs_write && !waitrequest_reg;
    assign laneWrite = avs_byteenable[1:0] & {2{writeAccept}};

    // Waitrequest rests high and drops for one cycle per request.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            waitrequest_reg <= 1'b1;
        end else if (!waitrequest_reg) begin
            waitrequest_reg <= 1'b1;
        end else if (avs_read || avs_write) begin
            waitrequest_reg <= 1'b0;
        end
    end

    // Read data is captured once and held until the next read.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            readdata_reg <= READ_ZERO;
        end else if (readAccept) begin
            readdata_reg <= readdata_next;
        end
    end

    assign avs_waitrequest = waitrequest_reg;
    assign avs_readdata = readdata_reg;

    logic selCh1A;
    logic selCh1B;
    logic selCh2A;
    logic selRole;

    assign selCh1A = (avs_address == OFFSET_CH1_COUNTER_A_STATUS);
    assign selCh1B = (avs_address == OFFSET_CH1_COUNTER_B_STATUS);
    assign selCh2A = (avs_address == OFFSET_CH2_COUNTER_A_STATUS);
    assign selRole = (avs_address == OFFSET_ROLE_SELECT);

    // ****************************************************************
    // Role select register
    // ****************************************************************

    // One bit per general register: one selects compare role, zero capture.
    logic [ROLE_WIDTH-1:0] role_reg;
    logic [ROLE_WIDTH-1:0] role_next;

    // Lanes merge separately; a disabled lane keeps its bits.
    always_comb begin
        role_next = role_reg;
        if (laneWrite[0]) begin
            role_next[LANE_WIDTH-1:0] = avs_writedata[LANE_WIDTH-1:0];
        end
        if (laneWrite[1]) begin
            role_next[ROLE_WIDTH-1:LANE_WIDTH] =
                avs_writedata[ROLE_WIDTH-1:LANE_WIDTH];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            role_reg <= ROLE_RESET;
        end else if (selRole) begin
            role_reg <= role_next;
        end
    end

    // ****************************************************************
    // Event sources for channel 1 general registers and counter B
    // ****************************************************************

    logic [CH1_GEN_FLAG_COUNT-1:0] ch1GenEvent;
    logic [CNT_WIDTH-1:0] ch1GenValue [CH1_GEN_FLAG_COUNT];

    assign ch1GenValue[0] = ch1CaptureCompareRegA;
    assign ch1GenValue[1] = ch1CaptureCompareRegB;

    for (genvar i = 0; i < CH1_GEN_FLAG_COUNT; i++) begin : gen_ch1_src
        tcsf_match_detect u_detect (
            .sys_clk(sys_clk),
            .reset(reset),
            .compareRole(role_reg[ROLE_CH1_LSB + i]),
            .captureStrobe(ch1CaptureStrobe[i]),
            .counterValue(ch1FreeCounterA),
            .matchValue(ch1GenValue[i]),
            .eventPulse(ch1GenEvent[i])
        );
    end

    logic ch1CompareEvent;
    logic ch1WrapEvent;
    logic [CNT_WIDTH-1:0] ch1CounterBPrev_reg;

    // output compare equality.
    // It has no capture role, so it is tied to compare.
    tcsf_match_detect u_ch1_compare (
        .sys_clk(sys_clk),
        .reset(reset),
        .compareRole(1'b1),
        .captureStrobe(1'b0),
        .counterValue(ch1FreeCounterB),
        .matchValue(ch1OutputCompareValue),
        .eventPulse(ch1CompareEvent)
    );

    // Previous count, to see a wrap.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ch1CounterBPrev_reg <= COUNTER_ZERO;
        end else begin
            ch1CounterBPrev_reg <= ch1FreeCounterB;
        end
    end

    // counter B wrap.
    // A load of zero from some other value is not a wrap.
    assign ch1WrapEvent = (ch1CounterBPrev_reg == COUNTER_MAX) &&
                          (ch1FreeCounterB == COUNTER_ZERO);

    // ****************************************************************
    // Event sources for channel 2
    // ****************************************************************

    logic [CH2_GEN_FLAG_COUNT-1:0] ch2GenEvent;
    logic [CNT_WIDTH-1:0] ch2GenValue [CH2_GEN_FLAG_COUNT];
    logic ch2WrapEvent;
    logic [CNT_WIDTH-1:0] ch2CounterAPrev_reg;

    assign ch2GenValue[0] = ch2CaptureCompareRegA;
    assign ch2GenValue[1] = ch2CaptureCompareRegB;
    assign ch2GenValue[2] = ch2CaptureCompareRegC;
    assign ch2GenValue[3] = ch2CaptureCompareRegD;
    assign ch2GenValue[4] = ch2CaptureCompareRegE;
    assign ch2GenValue[5] = ch2CaptureCompareRegF;
    assign ch2GenValue[6] = ch2CaptureCompareRegG;
    assign ch2GenValue[7] = ch2CaptureCompareRegH;

    for (genvar i = 0; i < CH2_GEN_FLAG_COUNT; i++) begin : gen_ch2_src
        tcsf_match_detect u_detect (
            .sys_clk(sys_clk),
            .reset(reset),
            .compareRole(role_reg[ROLE_CH2_LSB + i]),
            .captureStrobe(ch2CaptureStrobe[i]),
            .counterValue(ch2FreeCounterA),
            .matchValue(ch2GenValue[i]),
            .eventPulse(ch2GenEvent[i])
        );
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ch2CounterAPrev_reg <= COUNTER_ZERO;
        end else begin
            ch2CounterAPrev_reg <= ch2FreeCounterA;
        end
    end

    assign ch2WrapEvent = (ch2CounterAPrev_reg == COUNTER_MAX) &&
                          (ch2FreeCounterA == COUNTER_ZERO);

    // ****************************************************************
    // Write qualification
    // ****************************************************************

    logic ch1AWrite;
    logic ch1BWrite;
    logic ch2AWrite;
    logic [REG_WIDTH-1:0] zeroWrite;

    assign ch1AWrite = writeAccept && selCh1A;
    assign ch1BWrite = writeAccept && selCh1B;
    assign ch2AWrite = writeAccept && selCh2A;

    // only zero clears.
    // Only a zero in an enabled lane may clear; ones, reserved too, do nothing.
    assign zeroWrite = ~avs_writedata[REG_WIDTH-1:0] &
                       {{LANE_WIDTH{avs_byteenable[1]}}, {LANE_WIDTH{avs_byteenable[0]}}};

    // ****************************************************************
    // Status flags
    // ****************************************************************

    for (genvar i = 0; i < CH1_GEN_FLAG_COUNT; i++) begin : gen_ch1_flag
        tcsf_flag_cell u_flag (
            .sys_clk(sys_clk),
            .reset(reset),
            .setEvent(ch1GenEvent[i]),
            .readStrobe(readAccept && selCh1A),
            .writeStrobe(ch1AWrite),
            .clearWrite(ch1AWrite && zeroWrite[i]),
            .flagOut(ch1GeneralRegEventFlag[i])
        );
    end

    tcsf_flag_cell u_ch1_compare_flag (
        .sys_clk(sys_clk),
        .reset(reset),
        .setEvent(ch1CompareEvent),
        .readStrobe(readAccept && selCh1B),
        .writeStrobe(ch1BWrite),
        .clearWrite(ch1BWrite && zeroWrite[BIT_COMPARE_MATCH]),
        .flagOut(ch1OutputCompareMatchFlag)
    );

    tcsf_flag_cell u_ch1_wrap_flag (
        .sys_clk(sys_clk),
        .reset(reset),
        .setEvent(ch1WrapEvent),
        .readStrobe(readAccept && selCh1B),
        .writeStrobe(ch1BWrite),
        .clearWrite(ch1BWrite && zeroWrite[BIT_WRAP]),
        .flagOut(ch1CounterBWrapFlag)
    );

    for (genvar i = 0; i < CH2_GEN_FLAG_COUNT; i++) begin : gen_ch2_flag
        tcsf_flag_cell u_flag (
            .sys_clk(sys_clk),
            .reset(reset),
            .setEvent(ch2GenEvent[i]),
            .readStrobe(readAccept && selCh2A),
            .writeStrobe(ch2AWrite),
            .clearWrite(ch2AWrite && zeroWrite[i]),
            .flagOut(ch2GeneralRegEventFlag[i])
        );
    end

    tcsf_flag_cell u_ch2_wrap_flag (
        .sys_clk(sys_clk),
        .reset(reset),
        .setEvent(ch2WrapEvent),
        .readStrobe(readAccept && selCh2A),
        .writeStrobe(ch2AWrite),
        .clearWrite(ch2AWrite && zeroWrite[BIT_WRAP]),
        .flagOut(ch2CounterAWrapFlag)
    );

    // ****************************************************************
    // Read data assembly
    // ****************************************************************

    logic [REG_WIDTH-1:0] ch1AStatus;
    logic [REG_WIDTH-1:0] ch1BStatus;
    logic [REG_WIDTH-1:0] ch2AStatus;

    // unused bits read zero.
    // Words start from zero and only live flags are filled in.
    always_comb begin
        ch1AStatus = STATUS_RESET;
        ch1AStatus[CH1_GEN_FLAG_COUNT-1:0] = ch1GeneralRegEventFlag;
        ch1BStatus = STATUS_RESET;
        ch1BStatus[BIT_COMPARE_MATCH] = ch1OutputCompareMatchFlag;
        ch1BStatus[BIT_WRAP] = ch1CounterBWrapFlag;
        ch2AStatus = STATUS_RESET;
        ch2AStatus[CH2_GEN_FLAG_COUNT-1:0] = ch2GeneralRegEventFlag;
        ch2AStatus[BIT_WRAP] = ch2CounterAWrapFlag;
    end

    // Unmapped offsets answer with zero rather than stalling the bus.
    always_comb begin
        readdata_next = READ_ZERO;
        if (selCh1A) begin
            readdata_next[REG_WIDTH-1:0] = ch1AStatus;
        end else if (selCh1B) begin
            readdata_next[REG_WIDTH-1:0] = ch1BStatus;
        end else if (selCh2A) begin
            readdata_next[REG_WIDTH-1:0] = ch2AStatus;
        end else if (selRole) begin
            readdata_next[ROLE_WIDTH-1:0] = role_reg;
        end
    end

endmodule

// ==== common/tcsf_pkg.sv ====
/*
 * Shared constants for the timer channel status flag block: register
 * offsets, field positions, reset values and counter limits.
 * Assumes a 32-bit Avalon-MM slave with byte addresses and 16-bit registers.
 */
package tcsf_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 32;
    localparam int REG_WIDTH = 16;
    localparam int CNT_WIDTH = 16;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [ADDR_WIDTH-1:0] OFFSET_CH1_COUNTER_A_STATUS = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_CH1_COUNTER_B_STATUS = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_CH2_COUNTER_A_STATUS = 4'h8;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_ROLE_SELECT = 4'hc;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CH1_GEN_FLAG_COUNT = 2;
    localparam int CH2_GEN_FLAG_COUNT = 8;
    localparam int BIT_COMPARE_MATCH = 0;
    localparam int BIT_WRAP = 8;
    localparam int ROLE_CH1_LSB = 0;
    localparam int ROLE_CH2_LSB = 2;
    localparam int ROLE_WIDTH = 10;
    localparam int LANE_WIDTH = 8;

    // ****************************************************************
    // Reset values and counter limits
    // ****************************************************************
    localparam logic [REG_WIDTH-1:0] STATUS_RESET = 16'h0000;
    localparam logic [ROLE_WIDTH-1:0] ROLE_RESET = 10'h000;
    localparam logic [DATA_WIDTH-1:0] READ_ZERO = 32'h0000_0000;
    localparam logic [CNT_WIDTH-1:0] COUNTER_MAX = 16'hffff;
    localparam logic [CNT_WIDTH-1:0] COUNTER_ZERO = 16'h0000;

endpackage

// ==== rtl/tcsf_flag_cell.sv ====
/*
 * One sticky status flag with its read-as-one qualifier.
 * Assumes strobes come from logic on sys_clk and last one cycle each.
 */
`timescale 1ns/10ps
module tcsf_flag_cell
    import tcsf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic setEvent,
    input wire logic readStrobe,
    input wire logic writeStrobe,
    input wire logic clearWrite,
    output logic flagOut
);

    logic flag_reg;
    logic armed_reg;

    // ****************************************************************
    // Flag state
    // ****************************************************************

    // The set term is tested first, so an event in a clearing cycle survives.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flag_reg <= 1'b0;
        end else if (setEvent) begin
            flag_reg <= 1'b1;
        end else if (clearWrite && armed_reg) begin
            flag_reg <= 1'b0;
        end
    end

    // The qualifier remembers whether the last read saw this flag at one, until the next write to its register.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            armed_reg <= 1'b0;
        end else if (readStrobe) begin
            armed_reg <= flag_reg;
        end else if (writeStrobe) begin
            armed_reg <= 1'b0;
        end
    end

    assign flagOut = flag_reg;

endmodule

// ==== rtl/tcsf_match_detect.sv ====
/*
 * Event source for one general register: capture strobe or compare match.
 * Assumes counter, register value and strobe are synchronous to sys_clk.
 */
`timescale 1ns/10ps
module tcsf_match_detect
    import tcsf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic compareRole,
    input wire logic captureStrobe,
    input wire logic [CNT_WIDTH-1:0] counterValue,
    input wire logic [CNT_WIDTH-1:0] matchValue,
    output logic eventPulse
);

    logic isEqual;
    logic equalPrev_reg;

    assign isEqual = (counterValue == matchValue);

    // Only the first cycle of equality counts, so a counter that dwells on
    // the match value does not re-set a flag that software just cleared.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            equalPrev_reg <= 1'b0;
        end else begin
            equalPrev_reg <= isEqual;
        end
    end

    assign eventPulse = compareRole ? (isEqual && !equalPrev_reg) : captureStrobe;

endmodule

// ==== verification/tcsf_monitor.sv ====
/*
 * Checker for the timer channel status flag block: bus answer timing,
 * flag set causes, clearing and reserved read bits.
 * Assumes it is bound to tcsf_top and sees only the ports of that module.
 */
`timescale 1ns/10ps
module tcsf_monitor
    import tcsf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [ADDR_WIDTH-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_WIDTH-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [CNT_WIDTH-1:0] ch1FreeCounterA,
    input wire logic [CNT_WIDTH-1:0] ch1CaptureCompareRegA,
    input wire logic [CNT_WIDTH-1:0] ch1CaptureCompareRegB,
    input wire logic [CH1_GEN_FLAG_COUNT-1:0] ch1CaptureStrobe,
    input wire logic [CNT_WIDTH-1:0] ch1FreeCounterB,
    input wire logic [CNT_WIDTH-1:0] ch1OutputCompareValue,
    input wire logic [CNT_WIDTH-1:0] ch2FreeCounterA,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegE,
    input wire logic [CNT_WIDTH-1:0] ch2CaptureCompareRegH,
    input wire logic [CH2_GEN_FLAG_COUNT-1:0] ch2CaptureStrobe,
    input wire logic [CH1_GEN_FLAG_COUNT-1:0] ch1GeneralRegEventFlag,
    input wire logic ch1CounterBWrapFlag,
    input wire logic ch1OutputCompareMatchFlag,
    input wire logic ch2CounterAWrapFlag,
    input wire logic [CH2_GEN_FLAG_COUNT-1:0] ch2GeneralRegEventFlag
);
    // ****************************************************************
    // Helpers and sequences
    // ****************************************************************
    logic [12:0] allFlags;

    // All flags in one vector, so one check covers every clear.
    assign allFlags = {ch1GeneralRegEventFlag, ch1CounterBWrapFlag, ch1OutputCompareMatchFlag,
        ch2CounterAWrapFlag, ch2GeneralRegEventFlag};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence busReq;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence readAt(logic [ADDR_WIDTH-1:0] a);
        avs_read && avs_waitrequest && avs_address == a;
    endsequence
    // The reset guard keeps values held during reset from looking like a wrap.
    sequence wrapped(logic [CNT_WIDTH-1:0] cnt);
        !$past(reset) && $past(cnt) == COUNTER_MAX && cnt == COUNTER_ZERO;
    endsequence
    // A flag may only rise after a capture strobe or counter equality.
    property causedBy(logic flagBit, logic strobeBit, logic [CNT_WIDTH-1:0] cnt,
        logic [CNT_WIDTH-1:0] gr);
        $rose(flagBit) |-> $past(strobeBit || cnt == gr);
    endproperty

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_BUS_ANSWER: assert property (busReq |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bad waitrequest pulse");
    AST_CH1B_WRAP: assert property (wrapped(ch1FreeCounterB) |=> ch1CounterBWrapFlag)
        else $error("1B wrap flag not set");
    AST_CH2A_WRAP: assert property (wrapped(ch2FreeCounterA) |=> ch2CounterAWrapFlag)
        else $error("2A wrap flag not set");
    AST_CH1_CMP: assert property (!$past(reset) && $rose(ch1FreeCounterB == ch1OutputCompareValue)
        |=> ch1OutputCompareMatchFlag) else $error("compare match flag not set");
    AST_REGA_CAUSE: assert property (causedBy(ch1GeneralRegEventFlag[0], ch1CaptureStrobe[0],
        ch1FreeCounterA, ch1CaptureCompareRegA)) else $error("reg A flag rose without cause");
    AST_REGB_CAUSE: assert property (causedBy(ch1GeneralRegEventFlag[1], ch1CaptureStrobe[1],
        ch1FreeCounterA, ch1CaptureCompareRegB)) else $error("reg B flag rose without cause");
    AST_REGH_CAUSE: assert property (causedBy(ch2GeneralRegEventFlag[7], ch2CaptureStrobe[7],
        ch2FreeCounterA, ch2CaptureCompareRegH)) else $error("reg H flag rose without cause");
    AST_REGE_CAUSE: assert property (causedBy(ch2GeneralRegEventFlag[4], ch2CaptureStrobe[4],
        ch2FreeCounterA, ch2CaptureCompareRegE)) else $error("reg E flag rose without cause");
    AST_CLEAR_BY_WRITE: assert property (!$past(reset) && |($past(allFlags) & ~allFlags)
        |-> $past(avs_write && !avs_waitrequest)) else $error("flag cleared without a write");
    AST_RSV_CH1B: assert property (readAt(OFFSET_CH1_COUNTER_B_STATUS)
        |=> (avs_readdata & 32'hffff_fefe) == READ_ZERO) else $error("reserved bits set");
    AST_RSV_CH2A: assert property (readAt(OFFSET_CH2_COUNTER_A_STATUS)
        |=> (avs_readdata & 32'hffff_fe00) == READ_ZERO) else $error("reserved bits set");
endmodule

bind tcsf_top tcsf_monitor u_monitor (.*);

// ==== verification/tb_timer_channel_status_flags.sv ====
/*
 * Self-checking bench for the timer channel status flag block.
 * Assumes tcsf_top with its Avalon-MM slave and the bound checker.
 */
`timescale 1ns/10ps
module tb_timer_channel_status_flags
    import tcsf_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_WIDTH-1:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_WIDTH-1:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h3;
    logic [DATA_WIDTH-1:0] avs_readdata, rd;
    logic avs_waitrequest, ch1CounterBWrapFlag, ch1OutputCompareMatchFlag, ch2CounterAWrapFlag;
    logic [CNT_WIDTH-1:0] ch1FreeCounterA = 16'h0000;
    logic [CNT_WIDTH-1:0] ch1CaptureCompareRegA = 16'h0a0a;
    logic [CNT_WIDTH-1:0] ch1CaptureCompareRegB = 16'h0b0b;
    logic [CNT_WIDTH-1:0] ch1FreeCounterB = 16'h0000;
    logic [CNT_WIDTH-1:0] ch1OutputCompareValue = 16'h0055;
    logic [CNT_WIDTH-1:0] ch2FreeCounterA = 16'h0000;
    logic [CNT_WIDTH-1:0] gr2 [8];
    logic [CH1_GEN_FLAG_COUNT-1:0] ch1CaptureStrobe = 2'h0;
    logic [CH2_GEN_FLAG_COUNT-1:0] ch2CaptureStrobe = 8'h00;
    logic [CH1_GEN_FLAG_COUNT-1:0] ch1GeneralRegEventFlag;
    logic [CH2_GEN_FLAG_COUNT-1:0] ch2GeneralRegEventFlag;
    logic [ADDR_WIDTH-1:0] offs [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    tcsf_top uut (.*, .ch2CaptureCompareRegA(gr2[0]), .ch2CaptureCompareRegB(gr2[1]),
        .ch2CaptureCompareRegC(gr2[2]), .ch2CaptureCompareRegD(gr2[3]),
        .ch2CaptureCompareRegE(gr2[4]), .ch2CaptureCompareRegF(gr2[5]),
        .ch2CaptureCompareRegG(gr2[6]), .ch2CaptureCompareRegH(gr2[7]));

    // ****************************************************************
    // Clock, timeout and shared tasks
    // ****************************************************************
    // 40 ns clock.
    always #20 sys_clk = ~sys_clk;

    // A hung handshake would stall forever, so a cycle ceiling ends the run.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [DATA_WIDTH-1:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access; hit pulses the reg A capture strobe.
    task automatic bus(input logic wr, input logic [ADDR_WIDTH-1:0] a,
        input logic [DATA_WIDTH-1:0] d, input logic hit);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge sys_clk);
            ch1CaptureStrobe <= {1'b0, hit & avs_waitrequest};
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Writes of one, an unarmed zero write, then a proper read and clear.
    task automatic clear_seq(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] exp,
        flagMask);
        bus(1'b1, a, flagMask, 1'b0);
        bus(1'b1, a, 32'h0, 1'b0);
        bus(1'b0, a, 32'h0, 1'b0);
        check(rd, exp);
        bus(1'b1, a, 32'h0, 1'b0);
        bus(1'b0, a, 32'h0, 1'b0);
        check(rd, 32'h0);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        foreach (offs[i]) begin
            bus(1'b0, offs[i], 32'h0, 1'b0);
            check(rd, 32'h0);
        end
        bus(1'b1, 4'h2, 32'h3ff, 1'b0);
        bus(1'b0, 4'h2, 32'h0, 1'b0);
        check(rd, 32'h0);
    endtask

    task automatic t_wrap();
        @(posedge sys_clk);
        ch1FreeCounterB <= 16'hfffe;
        @(posedge sys_clk);
        ch1FreeCounterB <= 16'h0000;
        bus(1'b0, OFFSET_CH1_COUNTER_B_STATUS, 32'h0, 1'b0);
        check(rd, 32'h0);
        ch1FreeCounterB <= 16'hffff;
        ch2FreeCounterA <= 16'hffff;
        @(posedge sys_clk);
        ch1FreeCounterB <= 16'h0000;
        ch2FreeCounterA <= 16'h0000;
        repeat (2) @(posedge sys_clk);
        check(32'({ch1CounterBWrapFlag, ch2CounterAWrapFlag}), 32'h3);
        clear_seq(OFFSET_CH1_COUNTER_B_STATUS, 32'h100, 32'h101);
        clear_seq(OFFSET_CH2_COUNTER_A_STATUS, 32'h100, 32'h1ff);
    endtask

    task automatic t_ch1_compare();
        ch1FreeCounterB <= 16'h0054;
        @(posedge sys_clk);
        ch1FreeCounterB <= 16'h0055;
        repeat (2) @(posedge sys_clk);
        check(32'(ch1OutputCompareMatchFlag), 32'h1);
        clear_seq(OFFSET_CH1_COUNTER_B_STATUS, 32'h1, 32'h101);
    endtask

    task automatic t_capture();
        ch1CaptureStrobe <= 2'h3;
        ch2CaptureStrobe <= 8'hff;
        @(posedge sys_clk);
        ch1CaptureStrobe <= 2'h0;
        ch2CaptureStrobe <= 8'h00;
        clear_seq(OFFSET_CH1_COUNTER_A_STATUS, 32'h3, 32'h3);
        clear_seq(OFFSET_CH2_COUNTER_A_STATUS, 32'hff, 32'h1ff);
        bus(1'b0, OFFSET_CH1_COUNTER_A_STATUS, 32'h0, 1'b1);
        bus(1'b0, OFFSET_CH1_COUNTER_A_STATUS, 32'h0, 1'b0);
        bus(1'b1, OFFSET_CH1_COUNTER_A_STATUS, 32'h0, 1'b1);
        bus(1'b0, OFFSET_CH1_COUNTER_A_STATUS, 32'h0, 1'b0);
        check(rd, 32'h1);
        bus(1'b1, OFFSET_CH1_COUNTER_A_STATUS, 32'h0, 1'b0);
    endtask

    task automatic t_compare();
        bus(1'b1, OFFSET_ROLE_SELECT, 32'h3ff, 1'b0);
        bus(1'b0, OFFSET_ROLE_SELECT, 32'h0, 1'b0);
        check(rd, 32'h3ff);
        ch1CaptureStrobe <= 2'h1;
        ch2CaptureStrobe <= 8'h6f;
        ch1FreeCounterA <= 16'h0b0b;
        @(posedge sys_clk);
        ch1CaptureStrobe <= 2'h0;
        ch2CaptureStrobe <= 8'h00;
        ch2FreeCounterA <= 16'h2700;
        @(posedge sys_clk);
        ch2FreeCounterA <= 16'h2400;
        bus(1'b0, OFFSET_CH1_COUNTER_A_STATUS, 32'h0, 1'b0);
        check(rd, 32'h2);
        bus(1'b0, OFFSET_CH2_COUNTER_A_STATUS, 32'h0, 1'b0);
        check(rd, 32'h90);
        check(32'(ch2GeneralRegEventFlag), 32'h90);
    endtask

    // Reset for four cycles, then each scenario.
    initial begin
        foreach (gr2[i]) gr2[i] = 16'h2000 + 16'(i * 256);
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_wrap();
        t_ch1_compare();
        t_capture();
        t_compare();
        summarize();
    end
endmodule
